//--- design/svfc_pkg.sv
package svfc_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_VF       = 8;
    localparam int VF_W         = 3;
    localparam int QPF          = 2;        // queues per vf, static
    localparam int NUM_Q        = 16;
    localparam int Q_W          = 4;
    localparam int NUM_VEC      = 9;        // one per vf plus pf config vector
    localparam logic [3:0] PF_VEC = 4'h8;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] A_CTRL    = 8'h00; // pf flr, ari, pf rid
    localparam logic [7:0] A_IOV     = 8'h04; // first offset, stride
    localparam logic [7:0] A_VFFLR   = 8'h08; // write one: vf flr
    localparam logic [7:0] A_ERREN   = 8'h0c; // legacy enables
    localparam logic [7:0] A_AERMSK  = 8'h10; // unc mask, unc sev, cor mask
    localparam logic [7:0] A_NFSERR  = 8'h14; // device level errors, w1c
    localparam logic [7:0] A_VFSEL   = 8'h18; // vf window select
    localparam logic [7:0] A_VFSTAT  = 8'h1c; // selected vf status, w1c
    localparam logic [7:0] A_VFHDR   = 8'h20; // selected vf header log
    localparam logic [7:0] A_VFRID   = 8'h24; // selected vf rid, ro
    localparam logic [7:0] A_MSIX    = 8'h28; // vf msix enable bitmap
    localparam logic [7:0] A_DEVID   = 8'h2c; // pf device id
    localparam logic [7:0] A_GLOBAL  = 8'h30; // link/led/debug, pf only

    // ==========================================================
    // field positions
    localparam int CTRL_PFFLR   = 0;
    localparam int CTRL_ARI     = 1;
    localparam int CTRL_RID_LSB = 16;
    localparam int NFS_W        = 8;
    localparam int VST_W        = 14;       // 9 legacy + 5 function specific
    localparam int ERREN_W      = 6;
    localparam logic [15:0] PF_RID_RST = 16'h0000;
    localparam logic [15:0] DEVID_RST  = 16'h0000; // arbitrary value
    localparam logic [15:0] VF_DEV_OFS = 16'h0001; // vf device id = pf + this

    // ==========================================================
    // access origin of a bar0 request
    function automatic logic svfc_is_pf(input logic [VF_W:0] fn);
        return fn[VF_W];
    endfunction : svfc_is_pf
endpackage : svfc_pkg

//--- design/svfc_rid.sv
`timescale 1ns/10ps
module svfc_rid (
    input  wire logic [15:0] pf_rid_in,
    input  wire logic [15:0] first_ofs_in,
    input  wire logic [15:0] stride_in,
    input  wire logic        ari_in,
    input  wire logic [2:0]  vf_in,
    output logic      [15:0] rid_out
);
    logic [15:0] raw;
    // first vf at pf + offset, then stride apart
    always_comb begin
        raw = 16'(pf_rid_in + first_ofs_in + 16'(stride_in * 16'(vf_in)));
        if (ari_in) begin
            // dev+fn is one 8-bit function; lsb port, upper bits vf
            rid_out = {raw[15:8], raw[7:1], pf_rid_in[0]};
        end else begin
            // no devices beyond 0 on the pf bus: next bus, dev 0
            rid_out = {8'(raw[15:8] + 8'h01), 5'h00, raw[2:0]};
        end
    end
endmodule : svfc_rid

//--- design/svfc_vf_slot.sv
`timescale 1ns/10ps
module svfc_vf_slot (
    input  wire logic                        clk_in,
    input  wire logic                        arst_n_in,
    input  wire logic                        flr_in,
    input  wire logic [svfc_pkg::VST_W-1:0]  err_in,
    input  wire logic [31:0]                 hdr_in,
    input  wire logic [svfc_pkg::VST_W-1:0]  clr_in,
    output logic                             run_out,
    output logic      [svfc_pkg::VST_W-1:0]  stat_out,
    output logic      [31:0]                 hdr_out
);
    // per-vf state: only this vf's flr touches it
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run_out  <= 1'b0;
            stat_out <= '0;
            hdr_out  <= 32'h0000_0000;
        end else if (flr_in) begin
            run_out  <= 1'b0;
            stat_out <= '0;
            hdr_out  <= 32'h0000_0000;
        end else begin
            run_out  <= 1'b1;
            // set wins over a clear in the same cycle
            stat_out <= (stat_out & ~clr_in) | err_in;
            if (|err_in && stat_out == '0) begin
                hdr_out <= hdr_in;
            end
        end
    end
endmodule : svfc_vf_slot

//--- design/svfc_top.sv
`timescale 1ns/10ps
module svfc_top (
    input  wire logic                          clk_in,
    input  wire logic                          arst_n_in,
    input  wire logic                          wb_cyc_in,
    input  wire logic                          wb_stb_in,
    input  wire logic                          wb_we_in,
    input  wire logic [7:0]                    wb_adr_in,
    input  wire logic [3:0]                    wb_sel_in,
    input  wire logic [31:0]                   wb_dat_in,
    output logic      [31:0]                   wb_dat_out,
    output logic                               wb_ack_out,
    input  wire logic [svfc_pkg::VF_W:0]       bar_fn_in,
    input  wire logic                          bar_vld_in,
    input  wire logic [svfc_pkg::Q_W-1:0]      bar_q_in,
    input  wire logic                          bar_glb_in,
    output logic                               bar_ok_out,
    output logic      [svfc_pkg::Q_W-1:0]      bar_q_out,
    input  wire logic [svfc_pkg::NFS_W-1:0]    nfs_err_in,
    input  wire logic                          fs_vld_in,
    input  wire logic [svfc_pkg::VF_W-1:0]     fs_vf_in,
    input  wire logic [svfc_pkg::VST_W-1:0]    fs_err_in,
    input  wire logic [31:0]                   fs_hdr_in,
    output logic                               msg_vld_out,
    output logic      [15:0]                   msg_rid_out,
    output logic      [svfc_pkg::NUM_VF-1:0]   vf_run_out,
    output logic      [svfc_pkg::NUM_VF-1:0]   vf_msix_out,
    output logic                               vf_msi_out,
    output logic      [3:0]                    pf_vec_out,
    output logic      [15:0]                   vf_devid_out,
    output logic      [5:0]                    err_en_out,
    output logic      [31:0]                   glb_out
);
    // ==========================================================
    // pf control, reset by port reset; pf flr resets all but pf rid and device id
    logic        pf_flr_ff;
    logic        ari_ff;
    logic [15:0] pf_rid_ff;
    logic [15:0] first_ofs_ff;
    logic [15:0] stride_ff;
    logic [5:0]  err_en_ff;
    logic [31:0] aer_ff;
    logic [svfc_pkg::NFS_W-1:0]  nfs_ff;
    logic [svfc_pkg::VF_W-1:0]   vf_sel_ff;
    logic [svfc_pkg::NUM_VF-1:0] msix_ff;
    logic [15:0] devid_ff;
    logic [31:0] glb_ff;
    logic [svfc_pkg::NUM_VF-1:0] vf_flr_ff;
    logic                        wr_stb;
    logic                        rd_stb;
    logic [svfc_pkg::VST_W-1:0]  vst_clr;
    logic [svfc_pkg::VST_W-1:0]  vst    [svfc_pkg::NUM_VF];
    logic [31:0]                 vhdr   [svfc_pkg::NUM_VF];
    logic [svfc_pkg::NUM_VF-1:0] vrun;
    logic [15:0]                 sel_rid;
    logic [15:0]                 err_rid;
    logic [31:0]                 nxt_rdat;

    // new request taken once; ack holds one cycle then drops
    assign wr_stb = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in;
    assign rd_stb = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in;

    // ==========================================================
    // wishbone ack, one cycle after strobe
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= wb_cyc_in && wb_stb_in && !wb_ack_out;
        end
    end

    // ==========================================================
    // pf registers; pf flr self clears after one cycle reset pulse
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pf_flr_ff    <= 1'b0;
            ari_ff       <= 1'b0;
            pf_rid_ff    <= svfc_pkg::PF_RID_RST;
            first_ofs_ff <= 16'h0000;
            stride_ff    <= 16'h0000;
            err_en_ff    <= 6'h00;
            aer_ff       <= 32'h0000_0000;
            vf_sel_ff    <= '0;
            msix_ff      <= '0;
            devid_ff     <= svfc_pkg::DEVID_RST;
            glb_ff       <= 32'h0000_0000;
        end else if (pf_flr_ff) begin
            pf_flr_ff    <= 1'b0;
            ari_ff       <= 1'b0;
            first_ofs_ff <= 16'h0000;
            stride_ff    <= 16'h0000;
            err_en_ff    <= 6'h00;
            aer_ff       <= 32'h0000_0000;
            vf_sel_ff    <= '0;
            msix_ff      <= '0;
            glb_ff       <= 32'h0000_0000;
        end else if (wr_stb) begin
            unique case (wb_adr_in)
                svfc_pkg::A_CTRL: begin
                    pf_flr_ff <= wb_dat_in[svfc_pkg::CTRL_PFFLR];
                    ari_ff    <= wb_dat_in[svfc_pkg::CTRL_ARI];
                    pf_rid_ff <= wb_dat_in[svfc_pkg::CTRL_RID_LSB +: 16];
                end
                svfc_pkg::A_IOV: begin
                    first_ofs_ff <= wb_dat_in[15:0];
                    stride_ff    <= wb_dat_in[31:16];
                end
                svfc_pkg::A_ERREN:  err_en_ff <= wb_dat_in[5:0];
                svfc_pkg::A_AERMSK: aer_ff    <= wb_dat_in;
                svfc_pkg::A_VFSEL:  vf_sel_ff <= wb_dat_in[svfc_pkg::VF_W-1:0];
                svfc_pkg::A_MSIX:   msix_ff   <= wb_dat_in[svfc_pkg::NUM_VF-1:0];
                svfc_pkg::A_DEVID:  devid_ff  <= wb_dat_in[15:0];
                svfc_pkg::A_GLOBAL: glb_ff    <= wb_dat_in;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // vf flr pulses, write one per bit; pf flr hits all vfs
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vf_flr_ff <= '0;
        end else if (pf_flr_ff) begin
            vf_flr_ff <= '1;
        end else if (wr_stb && wb_adr_in == svfc_pkg::A_VFFLR) begin
            vf_flr_ff <= wb_dat_in[svfc_pkg::NUM_VF-1:0];
        end else begin
            vf_flr_ff <= '0;
        end
    end

    // ==========================================================
    // device level errors, single pf register, w1c, set wins
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            nfs_ff <= '0;
        end else if (pf_flr_ff) begin
            nfs_ff <= nfs_err_in;
        end else begin
            nfs_ff <= (nfs_ff & ~((wr_stb && wb_adr_in == svfc_pkg::A_NFSERR) ?
                       wb_dat_in[svfc_pkg::NFS_W-1:0] : '0)) | nfs_err_in;
        end
    end

    assign vst_clr = (wr_stb && wb_adr_in == svfc_pkg::A_VFSTAT) ?
                     wb_dat_in[svfc_pkg::VST_W-1:0] : '0;

    // ==========================================================
    // per-vf slots
    for (genvar g = 0; g < svfc_pkg::NUM_VF; g++) begin : g_vf
        svfc_vf_slot u_slot (
            .clk_in    (clk_in),
            .arst_n_in (arst_n_in),
            .flr_in    (vf_flr_ff[g]),
            .err_in    ((fs_vld_in && fs_vf_in == g) ? fs_err_in : '0),
            .hdr_in    (fs_hdr_in),
            .clr_in    ((vf_sel_ff == g) ? vst_clr : '0),
            .run_out   (vrun[g]),
            .stat_out  (vst[g]),
            .hdr_out   (vhdr[g])
        );
    end

    svfc_rid u_rid_sel (
        .pf_rid_in    (pf_rid_ff),
        .first_ofs_in (first_ofs_ff),
        .stride_in    (stride_ff),
        .ari_in       (ari_ff),
        .vf_in        (vf_sel_ff),
        .rid_out      (sel_rid)
    );

    svfc_rid u_rid_err (
        .pf_rid_in    (pf_rid_ff),
        .first_ofs_in (first_ofs_ff),
        .stride_in    (stride_ff),
        .ari_in       (ari_ff),
        .vf_in        (fs_vf_in),
        .rid_out      (err_rid)
    );

    // ==========================================================
    // error message, gated by shared enables, tagged with vf rid
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            msg_vld_out <= 1'b0;
            msg_rid_out <= 16'h0000;
        end else begin
            msg_vld_out <= fs_vld_in && |fs_err_in && |err_en_ff;
            msg_rid_out <= err_rid;
        end
    end

    // ==========================================================
    // bar0 decode: pf sees all; vf sees own queues at base 0
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bar_ok_out <= 1'b0;
            bar_q_out  <= '0;
        end else if (svfc_pkg::svfc_is_pf(bar_fn_in)) begin
            bar_ok_out <= bar_vld_in;
            bar_q_out  <= bar_q_in;
        end else begin
            // global space refused to vfs; queues past share refused
            bar_ok_out <= bar_vld_in && !bar_glb_in &&
                          bar_q_in < svfc_pkg::Q_W'(svfc_pkg::QPF);
            // static map: vf n owns queues n*QPF onward
            bar_q_out  <= svfc_pkg::Q_W'(bar_fn_in[svfc_pkg::VF_W-1:0] * svfc_pkg::QPF)
                          + bar_q_in;
        end
    end

    // ==========================================================
    // run state, vectors and ids driven out registered
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vf_run_out   <= '0;
            vf_msix_out  <= '0;
            vf_msi_out   <= 1'b0;
            pf_vec_out   <= svfc_pkg::PF_VEC;
            vf_devid_out <= 16'h0000;
            err_en_out   <= 6'h00;
            glb_out      <= 32'h0000_0000;
        end else begin
            vf_run_out   <= vrun & ~vf_flr_ff;
            vf_msix_out  <= msix_ff & vrun;
            vf_msi_out   <= 1'b0;
            pf_vec_out   <= svfc_pkg::PF_VEC;
            vf_devid_out <= 16'(devid_ff + svfc_pkg::VF_DEV_OFS);
            err_en_out   <= err_en_ff;
            glb_out      <= glb_ff;
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        nxt_rdat = 32'h0000_0000;
        unique case (wb_adr_in)
            svfc_pkg::A_CTRL:   nxt_rdat = {pf_rid_ff, 14'h0000, ari_ff, pf_flr_ff};
            svfc_pkg::A_IOV:    nxt_rdat = {stride_ff, first_ofs_ff};
            svfc_pkg::A_ERREN:  nxt_rdat = {26'h0000000, err_en_ff};
            svfc_pkg::A_AERMSK: nxt_rdat = aer_ff;
            svfc_pkg::A_NFSERR: nxt_rdat = {24'h000000, nfs_ff};
            svfc_pkg::A_VFSEL:  nxt_rdat = {29'h00000000, vf_sel_ff};
            svfc_pkg::A_VFSTAT: nxt_rdat = {vrun[vf_sel_ff], 17'h00000, vst[vf_sel_ff]};
            svfc_pkg::A_VFHDR:  nxt_rdat = vhdr[vf_sel_ff];
            svfc_pkg::A_VFRID:  nxt_rdat = {16'h0000, sel_rid};
            svfc_pkg::A_MSIX:   nxt_rdat = {24'h000000, msix_ff};
            svfc_pkg::A_DEVID:  nxt_rdat = {16'h0000, devid_ff};
            svfc_pkg::A_GLOBAL: nxt_rdat = glb_ff;
            default:            nxt_rdat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else if (rd_stb) begin
            wb_dat_out <= nxt_rdat;
        end
    end

    // ==========================================================
    // checks
    vf_msi_off_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !vf_msi_out) else $error("msi offered to vf");
    pf_vec_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        pf_vec_out == svfc_pkg::PF_VEC) else $error("pf vector lost");
    vf_flr_halt_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        vf_flr_ff[0] |=> !vf_run_out[0]) else $error("vf0 runs after flr");
    vf_flr_clr_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        vf_flr_ff[1] |=> vst[1] == '0 && vhdr[1] == 32'h0) else $error("vf1 log kept");
    flr_scope_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        |vf_flr_ff && !pf_flr_ff |=> $stable(err_en_ff) && $stable(glb_ff))
        else $error("vf flr touched shared state");
    pf_flr_all_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        pf_flr_ff |=> vf_flr_ff == '1 ##1 vf_run_out == '0)
        else $error("pf flr missed vfs");
    nfs_log_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        nfs_err_in[0] |=> nfs_ff[0]) else $error("device error lost");
    err_rid_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        fs_vld_in |=> msg_rid_out == $past(err_rid)) else $error("wrong msg rid");
    vf_glb_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        bar_vld_in && bar_glb_in && !bar_fn_in[svfc_pkg::VF_W] |=> !bar_ok_out)
        else $error("vf reached global space");
    ack_once_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        wb_ack_out |=> !wb_ack_out) else $error("ack held");

    // ==========================================================
    // message gating, bar reach and rid layout
    msg_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        msg_vld_out |-> $past(err_en_ff) != '0) else $error("msg sent while disabled");
    pf_bar_pass_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        bar_vld_in && bar_fn_in[svfc_pkg::VF_W] |=>
        bar_ok_out && bar_q_out == $past(bar_q_in)) else $error("pf bar access refused");
    vf_q_lim_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        bar_vld_in && !bar_fn_in[svfc_pkg::VF_W] &&
        bar_q_in >= svfc_pkg::Q_W'(svfc_pkg::QPF) |=> !bar_ok_out)
        else $error("vf reached foreign queue");
    vf_err_log_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        fs_vld_in && !vf_flr_ff[fs_vf_in] |=>
        (vst[$past(fs_vf_in)] & $past(fs_err_in)) == $past(fs_err_in))
        else $error("vf error not logged");
    ari_port_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ari_ff |-> sel_rid[0] == pf_rid_ff[0]) else $error("ari port bit wrong");
    non_ari_dev_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !ari_ff |-> sel_rid[7:3] == 5'h00) else $error("non-ari vf off device 0");
    // main scenarios seen
    c_pf_flr_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) pf_flr_ff);
    c_ari_c: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        ari_ff && rd_stb && wb_adr_in == svfc_pkg::A_VFRID);
    c_vf_flr_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) |vf_flr_ff);
    c_msg_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) msg_vld_out);
    c_vf_bar_c: cover property (@(posedge clk_in) disable iff (!arst_n_in)
        bar_ok_out && !$past(bar_fn_in[svfc_pkg::VF_W]));
endmodule : svfc_top

//--- dv/svfc_host.sv
`timescale 1ns/10ps
// ==========================================================
// root complex side: bar accesses, error events, message sink
module svfc_host (
    input  wire logic        clk_in,
    input  wire logic        bar_ok_in,
    input  wire logic [3:0]  bar_q_in,
    input  wire logic        msg_vld_in,
    input  wire logic [15:0] msg_rid_in,
    output logic      [3:0]  bar_fn_out,
    output logic             bar_vld_out,
    output logic      [3:0]  bar_q_out,
    output logic             bar_glb_out,
    output logic      [7:0]  nfs_err_out,
    output logic             fs_vld_out,
    output logic      [2:0]  fs_vf_out,
    output logic      [13:0] fs_err_out,
    output logic      [31:0] fs_hdr_out
);
    // idle values; released bar queue, fs error and fs header get inverted so stale data never looks valid
    initial begin
        {bar_fn_out, bar_vld_out, bar_q_out, bar_glb_out} = '0;
        {nfs_err_out, fs_vld_out, fs_vf_out, fs_err_out, fs_hdr_out} = '0;
    end
    // one-cycle bar request, answer registered one edge later
    task automatic bar_req(input logic [3:0] fn, input logic [3:0] q, input logic glb,
                           output logic ok, output logic [3:0] pq);
        @(posedge clk_in);
        {bar_fn_out, bar_q_out, bar_glb_out, bar_vld_out} <= {fn, q, glb, 1'b1};
        @(posedge clk_in);
        {bar_q_out, bar_vld_out} <= {~q, 1'b0};
        #1;
        ok = bar_ok_in;
        pq = bar_q_in;
    endtask : bar_req
    // function specific error pulse, message captured one edge later
    task automatic fs_evt(input logic [2:0] vf, input logic [13:0] e, input logic [31:0] h,
                          output logic mv, output logic [15:0] rid);
        @(posedge clk_in);
        {fs_vld_out, fs_vf_out, fs_err_out, fs_hdr_out} <= {1'b1, vf, e, h};
        @(posedge clk_in);
        {fs_vld_out, fs_err_out, fs_hdr_out} <= {1'b0, ~e, ~h};
        #1;
        mv = msg_vld_in;
        rid = msg_rid_in;
    endtask : fs_evt
    // device level error pulse
    task automatic nfs_evt(input logic [7:0] e);
        @(posedge clk_in);
        nfs_err_out <= e;
        @(posedge clk_in);
        nfs_err_out <= 8'h00;
    endtask : nfs_evt
endmodule : svfc_host

//--- dv/svfc_top_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module svfc_top_bench;
    logic clk_in = 1'b0, arst_n_in = 1'b0, cyc = 1'b0, we = 1'b0, ok, mv;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, wb_dat_out;
    logic [15:0] rid, msg_rid_out, vf_devid_out;
    logic [3:0]  bfn, bq, bqo, pq, pf_vec_out;
    logic [7:0]  nfs, vf_run_out, vf_msix_out;
    logic [2:0]  fvf;
    logic [13:0] fer;
    logic [31:0] fhd, glb_out;
    logic [5:0]  err_en_out;
    logic        bvld, bglb, bok, fvld, wb_ack_out, msg_vld_out, vf_msi_out;
    int errors = 0, cmp_count = 0, cycles = 0;
    always #12.5 clk_in = ~clk_in;
    svfc_top dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wd),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .bar_fn_in(bfn), .bar_vld_in(bvld),
        .bar_q_in(bq), .bar_glb_in(bglb), .bar_ok_out(bok), .bar_q_out(bqo), .nfs_err_in(nfs),
        .fs_vld_in(fvld), .fs_vf_in(fvf), .fs_err_in(fer), .fs_hdr_in(fhd),
        .msg_vld_out(msg_vld_out), .msg_rid_out(msg_rid_out), .vf_run_out(vf_run_out),
        .vf_msix_out(vf_msix_out), .vf_msi_out(vf_msi_out), .pf_vec_out(pf_vec_out),
        .vf_devid_out(vf_devid_out), .err_en_out(err_en_out), .glb_out(glb_out));
    svfc_host host_u (.clk_in(clk_in), .bar_ok_in(bok), .bar_q_in(bqo), .msg_vld_in(msg_vld_out),
        .msg_rid_in(msg_rid_out), .bar_fn_out(bfn), .bar_vld_out(bvld), .bar_q_out(bq),
        .bar_glb_out(bglb), .nfs_err_out(nfs), .fs_vld_out(fvld), .fs_vf_out(fvf),
        .fs_err_out(fer), .fs_hdr_out(fhd));
    // ==========================================================
    // verdict; the only exit of the run
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    // hang guard, far above the some 165 cycles the tests need
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end
    // classic wishbone cycle: hold until ack, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {cyc, we, adr, wd} <= {1'b1, w, a, d};
        // no local limit: only the hang guard ends a wait
        do begin @(posedge clk_in); end while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        cyc <= 1'b0;
        // idle edge: registered outputs fed by the write settle before checks
        @(posedge clk_in);
    endtask : wb
    // vf window read: select then read
    task automatic vrd(input logic [2:0] v, input logic [7:0] a);
        wb(1'b1, svfc_pkg::A_VFSEL, {29'h0, v});
        wb(1'b0, a, 32'h0);
    endtask : vrd
    // ==========================================================
    // test sequence
    initial begin
        repeat (5) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        `CHK(pf_vec_out, svfc_pkg::PF_VEC)
        `CHK(vf_msi_out, 1'b0)
        `CHK(vf_run_out, 8'hff)
        wb(1'b1, svfc_pkg::A_MSIX, 32'h5a);
        `CHK(vf_msix_out, 8'h5a)
        wb(1'b1, svfc_pkg::A_DEVID, 32'h1234);
        `CHK(vf_devid_out, 16'h1235)
        wb(1'b1, svfc_pkg::A_ERREN, 32'h3f);
        `CHK(err_en_out, 6'h3f)
        wb(1'b1, svfc_pkg::A_AERMSK, 32'ha5c3_0f1e);
        wb(1'b0, svfc_pkg::A_AERMSK, 32'h0);
        `CHK(rd, 32'ha5c3_0f1e)
        wb(1'b1, svfc_pkg::A_GLOBAL, 32'h0bad_cafe);
        `CHK(glb_out, 32'h0bad_cafe)
        wb(1'b0, 8'h3c, 32'h0);
        `CHK(rd, 32'h0)
        // rid layout in both modes, first and last vf
        wb(1'b1, svfc_pkg::A_IOV, 32'h0002_0002);
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, svfc_pkg::A_CTRL, {16'h0100, 14'h0, m[0], 1'b0});
            for (int v = 0; v < 8; v += 7) begin
                vrd(v[2:0], svfc_pkg::A_VFRID);
                if (m == 1) `CHK(rd[15:0], 16'h0102 + 16'(2 * v))
                else `CHK(rd[15:0], {8'h02, 5'h0, 3'(2 + 2 * v)})
            end
        end
        // function specific error on vf 3: message, status, first header only
        host_u.fs_evt(3'd3, 14'h0004, 32'h1111_2222, mv, rid);
        `CHK({mv, rid}, {1'b1, 16'h0108})
        host_u.fs_evt(3'd3, 14'h2000, 32'h3333_4444, mv, rid);
        vrd(3'd3, svfc_pkg::A_VFSTAT);
        `CHK(rd & 32'h8000_3fff, 32'h8000_2004)
        vrd(3'd3, svfc_pkg::A_VFHDR);
        `CHK(rd, 32'h1111_2222)
        vrd(3'd2, svfc_pkg::A_VFSTAT);
        `CHK(rd[13:0], 14'h0)
        host_u.nfs_evt(8'h81);
        wb(1'b0, svfc_pkg::A_NFSERR, 32'h0);
        `CHK(rd[7:0], 8'h81)
        // vf flr on vf 3 leaves shared state and other vfs
        wb(1'b1, svfc_pkg::A_VFFLR, 32'h08);
        repeat (3) @(posedge clk_in);
        `CHK(vf_run_out & 8'hf7, 8'hf7)
        `CHK(err_en_out, 6'h3f)
        vrd(3'd3, svfc_pkg::A_VFSTAT);
        `CHK(rd[13:0], 14'h0)
        vrd(3'd3, svfc_pkg::A_VFHDR);
        `CHK(rd, 32'h0)
        wb(1'b0, svfc_pkg::A_NFSERR, 32'h0);
        `CHK(rd[7:0], 8'h81)
        wb(1'b1, svfc_pkg::A_NFSERR, 32'h81);
        wb(1'b0, svfc_pkg::A_NFSERR, 32'h0);
        `CHK(rd[7:0], 8'h00)
        // bar0 decode: vf queue remap, vf limits, pf reach
        host_u.bar_req(4'h2, 4'h1, 1'b0, ok, pq);
        `CHK({ok, pq}, {1'b1, 4'h5})
        host_u.bar_req(4'h2, 4'h2, 1'b0, ok, pq);
        `CHK(ok, 1'b0)
        host_u.bar_req(4'h2, 4'h0, 1'b1, ok, pq);
        `CHK(ok, 1'b0)
        host_u.bar_req(4'h8, 4'h9, 1'b1, ok, pq);
        `CHK({ok, pq}, {1'b1, 4'h9})
        // pf flr clears the function's configuration
        wb(1'b1, svfc_pkg::A_CTRL, 32'h1);
        repeat (3) @(posedge clk_in);
        `CHK(err_en_out, 6'h00)
        end_sim();
    end
endmodule : svfc_top_bench
